// file: core/arb_ctl_defs.svh
// Constants for the local-bus arbitration control block.
// Assumes inclusion by the design file by bare name.
`ifndef ARB_CTL_DEFS_SVH
`define ARB_CTL_DEFS_SVH
`define ARB_CTL_ADDR      12'h000
`define ARB_STATUS_ADDR   12'h004
`define ARB_ADDR_MSB      11
`define BIT_LOCK          0
`define BIT_WB_MODE       1
`define BIT_REQ1_EN       2
`define BIT_PAIR1_SEL     3
`define BIT_REQ2_EN       4
`define BIT_EXTERNAL_IO_CHIP_SELECT_EN       5
`define BIT_PIN3_SEL      6
`define BIT_STRAP_IND     7
`define CTL_RESET_LOW     6'h00
`define STRAP_SETTLE      2'h2
`define WB_PULSE_NS       80
`define CLK_PERIOD_NS     40
`define WB_PULSE_CYCLES   ((`WB_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: core/arb_ctl_pkg.sv
// Types shared by the arbitration control block.
// Assumes the constants header is on the include path.
`default_nettype none
package arb_ctl_pkg;
	typedef struct packed {
		logic strap_ind;
		logic pin3_sel;
		logic external_io_chip_select_en;
		logic req2_en;
		logic pair1_sel;
		logic req1_en;
		logic wb_mode;
		logic lock;
	} ctl_t;
	typedef enum logic [1:0] {
		hold_idle,
		hold_on,
		hold_pulse
	} hold_state_t;
endpackage
`default_nettype wire

// file: core/local_bus_arbitration_control.sv
// Local-bus arbitration control: control byte on APB, hold request shaping,
// master request gating, shared pin function select and I/O decode qualify.
// Assumes pclk at 25 MHz; all pins other than APB and bus_request come from outside the domain.
//
// Added by the designer: the placing of the registers and the APB register port.
`include "arb_ctl_defs.svh"
`default_nettype none

// Two-flop synchroniser for one pin input
module pin_sync_2ff #(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic pin,
	output logic      synced
);
	logic stage1;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= RESET_VAL;
			synced <= RESET_VAL;
		end else begin
			stage1 <= pin;
			synced <= stage1;
		end
	end
endmodule

module local_bus_arbitration_control
	import arb_ctl_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        strap_grant_pin,
	input  wire logic        cpu_writeback_indication,
	input  wire logic        cpu_bus_hold_ack,
	input  wire logic        local_master_request_1_n,
	input  wire logic        local_master_request_2_n,
	input  wire logic        external_io_chip_select_n,
	input  wire logic        internal_io_hit,
	input  wire logic        bus_request,
	output logic             cpu_hold_request,
	output logic             address_float,
	output logic             local_master_grant_1_n,
	output logic             local_master_grant_2_n,
	output logic             pair1_request_grant_mode,
	output logic             pin3_request_mode,
	output logic             system_address_high_drive,
	output logic             internal_io_select
);
	ctl_t        ctl;
	hold_state_t hold_state;
	logic        strap_taken;
	logic [1:0]  strap_age;
	logic        strap_sync;
	logic        wb_sync;
	logic        req1_sync;
	logic        req2_sync;
	logic        external_io_chip_select_sync;
	logic        cpu_bus_hold_ack_sync;
	logic        hit_sync;
	logic        wb_prev;
	logic [3:0]  pulse_count;
	logic        req1_live;
	logic        req2_live;
	logic        want_hold;
	logic        wb_fall;
	logic        wr_ctl;

	// Two-flop synchronisers for every pin input except bus_request; idle levels on reset
	pin_sync_2ff #(
		.RESET_VAL(1'b0)
	) u_sync_strap (
		.clk   (pclk),
		.rst_n (presetn),
		.pin   (strap_grant_pin),
		.synced(strap_sync)
	);

	pin_sync_2ff #(
		.RESET_VAL(1'b1)
	) u_sync_wb (
		.clk   (pclk),
		.rst_n (presetn),
		.pin   (cpu_writeback_indication),
		.synced(wb_sync)
	);

	pin_sync_2ff #(
		.RESET_VAL(1'b1)
	) u_sync_req1 (
		.clk   (pclk),
		.rst_n (presetn),
		.pin   (local_master_request_1_n),
		.synced(req1_sync)
	);

	pin_sync_2ff #(
		.RESET_VAL(1'b1)
	) u_sync_req2 (
		.clk   (pclk),
		.rst_n (presetn),
		.pin   (local_master_request_2_n),
		.synced(req2_sync)
	);

	pin_sync_2ff #(
		.RESET_VAL(1'b1)
	) u_sync_external_io_chip_select (
		.clk   (pclk),
		.rst_n (presetn),
		.pin   (external_io_chip_select_n),
		.synced(external_io_chip_select_sync)
	);

	pin_sync_2ff #(
		.RESET_VAL(1'b0)
	) u_sync_cpu_bus_hold_ack (
		.clk   (pclk),
		.rst_n (presetn),
		.pin   (cpu_bus_hold_ack),
		.synced(cpu_bus_hold_ack_sync)
	);

	pin_sync_2ff #(
		.RESET_VAL(1'b0)
	) u_sync_hit (
		.clk   (pclk),
		.rst_n (presetn),
		.pin   (internal_io_hit),
		.synced(hit_sync)
	);

	assign wr_ctl = psel && penable && pwrite && (paddr == `ARB_CTL_ADDR);

	// Control byte; bits 7:6 loaded from the strap after the synchroniser settles
	// Waiting for the settle avoids latching the synchroniser's reset level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl         <= ctl_t'({2'h0, `CTL_RESET_LOW});
			strap_taken <= 1'b0;
			strap_age   <= 2'h0;
		end else if (strap_age != `STRAP_SETTLE) begin
			strap_age <= strap_age + 2'h1;
		end else if (!strap_taken) begin
			strap_taken   <= 1'b1;
			ctl.strap_ind <= ~strap_sync;
			ctl.pin3_sel  <= ~strap_sync;
		end else if (wr_ctl) begin
			ctl.lock      <= pwdata[`BIT_LOCK];
			ctl.wb_mode   <= pwdata[`BIT_WB_MODE];
			ctl.req1_en   <= pwdata[`BIT_REQ1_EN];
			ctl.pair1_sel <= pwdata[`BIT_PAIR1_SEL];
			ctl.req2_en   <= pwdata[`BIT_REQ2_EN];
			ctl.external_io_chip_select_en   <= pwdata[`BIT_EXTERNAL_IO_CHIP_SELECT_EN];
			ctl.pin3_sel  <= pwdata[`BIT_PIN3_SEL];
		end
	end

	// APB answer: zero wait states, error on unmapped address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && (paddr != `ARB_CTL_ADDR)
				&& (paddr != `ARB_STATUS_ADDR);
			if (psel && !penable && !pwrite) begin
				if (paddr == `ARB_CTL_ADDR)
					prdata <= {24'h00_0000, ctl};
				else if (paddr == `ARB_STATUS_ADDR)
					prdata <= {29'h0000_0000, address_float, cpu_bus_hold_ack_sync,
						cpu_hold_request};
				else
					prdata <= 32'h0000_0000;
			end
		end
	end

	// Local master request inputs count only with their pin function selected; bus_request always counts
	assign req1_live = ctl.req1_en && ctl.pair1_sel && !req1_sync;
	assign req2_live = ctl.req2_en && ctl.pin3_sel && !req2_sync;
	assign want_hold = bus_request || req1_live || req2_live;
	assign wb_fall   = wb_prev && !wb_sync;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wb_prev <= 1'b1;
		else
			wb_prev <= wb_sync;
	end

	// Hold request sequencing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_state       <= hold_idle;
			cpu_hold_request <= 1'b0;
			address_float    <= 1'b0;
			pulse_count      <= 4'h0;
		end else begin
			case (hold_state)
				hold_idle: begin
					address_float <= 1'b0;
					// Lock also blocks the writeback pulse from raising hold
					if (ctl.wb_mode && wb_fall && !ctl.lock) begin
						hold_state       <= hold_pulse;
						cpu_hold_request <= 1'b1;
						address_float    <= 1'b1;
						pulse_count      <= 4'(`WB_PULSE_CYCLES);
					end else if (want_hold && !ctl.lock
						&& (ctl.wb_mode || wb_sync)) begin
						hold_state       <= hold_on;
						cpu_hold_request <= 1'b1;
					end
				end
				hold_on: begin
					if (!want_hold || (!ctl.wb_mode && !wb_sync)) begin
						hold_state       <= hold_idle;
						cpu_hold_request <= 1'b0;
					end
				end
				hold_pulse: begin
					if (pulse_count <= 4'h1) begin
						hold_state       <= hold_idle;
						cpu_hold_request <= 1'b0;
						address_float    <= 1'b0;
						pulse_count      <= 4'h0;
					end else
						pulse_count <= pulse_count - 4'h1;
				end
				default: begin
					hold_state       <= hold_idle;
					cpu_hold_request <= 1'b0;
					address_float    <= 1'b0;
				end
			endcase
		end
	end

	// Grants and pin function outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			local_master_grant_1_n    <= 1'b1;
			local_master_grant_2_n    <= 1'b1;
			pair1_request_grant_mode  <= 1'b0;
			pin3_request_mode         <= 1'b0;
			system_address_high_drive <= 1'b0;
		end else begin
			local_master_grant_1_n    <= !(cpu_bus_hold_ack_sync && req1_live
				&& hold_state == hold_on);
			local_master_grant_2_n    <= !(cpu_bus_hold_ack_sync && req2_live && !req1_live
				&& hold_state == hold_on);
			pair1_request_grant_mode  <= ctl.pair1_sel;
			pin3_request_mode         <= ctl.pin3_sel;
			system_address_high_drive <= !ctl.pin3_sel;
		end
	end

	// Internal I/O decode qualify
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			internal_io_select <= 1'b0;
		else if (ctl.external_io_chip_select_en && ctl.pin3_sel)
			internal_io_select <= hit_sync && !external_io_chip_select_sync;
		else
			internal_io_select <= hit_sync;
	end
endmodule
`default_nettype wire

// file: bench/arb_ctl_props.sv
// Checker for the arbitration control ports.
// Assumes a bind to the top module; control byte mirrored from writes.
`default_nettype none
module arb_ctl_props (
	input wire logic	pclk,
	input wire logic	presetn,
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic [11:0]	paddr,
	input wire logic [31:0]	pwdata,
	input wire logic	cpu_writeback_indication,
	input wire logic	cpu_hold_request,
	input wire logic	address_float,
	input wire logic	local_master_grant_1_n,
	input wire logic	local_master_grant_2_n,
	input wire logic	pair1_request_grant_mode,
	input wire logic	pin3_request_mode
);
	wire	wr = psel && penable && pwrite && paddr == 12'h000;
	logic [7:0]	wb;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wb <= 8'h00;
		else if (wr)
			wb <= pwdata[7:0];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_LOCK: assert property (wb[0] && !cpu_hold_request |=> !cpu_hold_request)
		else $error("hold rose under lock");
	AST_WB: assert property ((!wb[1] && !cpu_writeback_indication) [*5] |-> !cpu_hold_request)
		else $error("hold high during writeback");
	AST_PULSE: assert property ($rose(address_float) |-> address_float [*2] ##1 !address_float)
		else $error("float pulse length wrong");
	AST_FLTH: assert property (address_float |-> cpu_hold_request)
		else $error("float without hold");
	AST_GNT1: assert property (!local_master_grant_1_n |-> pair1_request_grant_mode)
		else $error("grant 1 without pin function");
	AST_GNT2: assert property (!local_master_grant_2_n |-> pin3_request_mode)
		else $error("grant 2 without pin function");
	AST_PAIR: assert property (wr |-> ##[1:2] pair1_request_grant_mode == wb[3])
		else $error("pair select not following bit 3");
	AST_PIN3: assert property (wr |-> ##[1:2] pin3_request_mode == wb[6])
		else $error("pin select not following bit 6");
	C_PULSE: cover property ($rose(address_float));
	C_GNT1: cover property (!local_master_grant_1_n);
	C_LOCK: cover property (wb[0] && cpu_hold_request);
endmodule
bind local_bus_arbitration_control arb_ctl_props u_props (.*);
`default_nettype wire

// file: bench/cpu_side_model.sv
// CPU model: acknowledges hold after one or three cycles.
// Assumes the hold request is a level from the block.
`default_nettype none
module cpu_side_model (
	input wire logic	pclk,
	input wire logic	presetn,
	input wire logic	cpu_hold_request,
	input wire logic	slow,
	output var logic	cpu_bus_hold_ack
);
	logic [1:0]	cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 2'h0;
			cpu_bus_hold_ack <= 1'b0;
		end else if (!cpu_hold_request) begin
			cnt <= 2'h0;
			cpu_bus_hold_ack <= 1'b0;
		end else if (slow && cnt != 2'h2)
			cnt <= cnt + 2'h1;
		else
			cpu_bus_hold_ack <= 1'b1;
	end
endmodule
`default_nettype wire

// file: bench/local_bus_arbitration_control_tb_top.sv
// Testbench for the arbitration control block.
// Assumes the CPU model on the hold handshake; strap held low.
`default_nettype none
`define CK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module local_bus_arbitration_control_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic	pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0]	paddr = 12'h000;
	logic [31:0]	pwdata = 32'h0, rd, prdata;
	logic	wbi = 1, r1 = 1, cs = 1, hit = 0, breq = 0, slow = 0;
	logic	err, fl, hold, ack, flt, g1, iosel, rdy, pm3;
	int	failures = 0, num_checks = 0, cyc = 0;
	local_bus_arbitration_control u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready(rdy), .pslverr(err), .strap_grant_pin(1'b0),
		.cpu_writeback_indication(wbi), .cpu_bus_hold_ack(ack),
		.local_master_request_1_n(r1), .local_master_request_2_n(1'b1),
		.external_io_chip_select_n(cs), .internal_io_hit(hit), .bus_request(breq),
		.cpu_hold_request(hold), .address_float(flt), .local_master_grant_1_n(g1),
		.local_master_grant_2_n(), .pair1_request_grant_mode(), .pin3_request_mode(pm3),
		.system_address_high_drive(), .internal_io_select(iosel));
	cpu_side_model u_cpu (.pclk, .presetn, .cpu_hold_request(hold), .slow,
		.cpu_bus_hold_ack(ack));
	initial begin
		forever #20 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (rdy !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic t_regs();
		bus(0, 12'h000, 8'h00);
		`CK("ctl", 32'hC0, rd)
		bus(1, 12'h000, 8'h3C);
		bus(0, 12'h000, 8'h00);
		`CK("ro", 32'hBC, rd)
		`CK("pin3", 1'b0, pm3)
	endtask
	task automatic t_lock();
		bus(1, 12'h000, 8'h43);
		breq <= 1'b1;
		wt(4);
		`CK("lock", 1'b0, hold)
		bus(1, 12'h000, 8'h42);
		wt(2);
		`CK("hold", 1'b1, hold)
		bus(1, 12'h000, 8'h43);
		wt(2);
		`CK("kept", 1'b1, hold)
		breq <= 1'b0;
		wt(3);
		`CK("drop", 1'b0, hold)
	endtask
	task automatic t_wb();
		bus(1, 12'h000, 8'h40);
		breq <= 1'b1;
		wbi <= 1'b0;
		wt(5);
		`CK("wb0", 1'b0, hold)
		wbi <= 1'b1;
		breq <= 1'b0;
		bus(1, 12'h000, 8'h42);
		wbi <= 1'b0;
		fl = 1'b0;
		repeat (8) begin
			@(posedge pclk);
			fl |= flt;
		end
		`CK("float", 1'b1, fl)
		`CK("end", 1'b0, flt)
		wbi <= 1'b1;
	endtask
	task automatic t_gnt();
		bus(1, 12'h000, 8'h4C);
		slow <= 1'b1;
		r1 <= 1'b0;
		wt(14);
		`CK("gnt", 1'b0, g1)
		r1 <= 1'b1;
		bus(1, 12'h000, 8'h44);
		wt(6);
		r1 <= 1'b0;
		wt(14);
		`CK("nogr", 1'b1, g1)
		r1 <= 1'b1;
	endtask
	task automatic t_io();
		bus(1, 12'h000, 8'h60);
		hit <= 1'b1;
		wt(5);
		`CK("cs1", 1'b0, iosel)
		cs <= 1'b0;
		wt(5);
		`CK("cs0", 1'b1, iosel)
		cs <= 1'b1;
		bus(1, 12'h000, 8'h40);
		wt(5);
		`CK("a09", 1'b1, iosel)
	endtask
	initial begin
		wt(2);
		presetn <= 1'b1;
		wt(4);
		t_regs();
		t_lock();
		t_wb();
		t_gnt();
		t_io();
		stop_test();
	end
endmodule
`default_nettype wire
